// ---- logic/exec_pkg.sv ----
// constants, register map and command codes for the arithmetic and branch unit
package exec_pkg;
  // register byte addresses on the control bus
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DST = 8'h04;
  localparam logic [7:0] ADDR_SRC = 8'h08;
  localparam logic [7:0] ADDR_PAIR = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_XADR = 8'h18;
  localparam logic [7:0] ADDR_CFG = 8'h1c;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  localparam logic [7:0] ADDR_STACK = 8'h24;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_COND_LSB = 4;
  // configuration register fields
  localparam int CFG_AMODE_LSB = 0;
  localparam int CFG_PMODE_LSB = 2;

  // status flag positions inside the 4-bit flag store; bus view sits at bits 7:4
  localparam int ST_C = 3;
  localparam int ST_N = 2;
  localparam int ST_Z = 1;
  localparam int ST_I = 0;
  localparam int STAT_LSB = 4;

  // reset values
  localparam logic [3:0] STAT_RST = 4'h0;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP, OP_COMPARE_ACC_EXTENDED, OP_DAC, OP_DSB, OP_DEC, OP_SUBTRACT_ONE_PAIR, OP_INC, OP_INV,
    OP_COUNT_DOWN_LOOP_BRANCH, OP_JMP, OP_JCOND, OP_GLOBAL_IRQ_OFF, OP_GLOBAL_IRQ_ON, OP_IDLE, OP_RETURN_FROM_INTERRUPT, OP_POPST
  } op_t;

  // extended operand addressing
  typedef enum logic [1:0] {AM_DIRECT, AM_INDIRECT, AM_INDEXED, AM_RSVD} amode_t;
  // low-power flavour taken by the idle command
  typedef enum logic [1:0] {PM_NMOS, PM_WAKE, PM_HALT_OFF, PM_HALT_ON} pmode_t;
  // branch conditions
  typedef enum logic [2:0] {CC_C, CC_NC, CC_Z, CC_NZ, CC_N, CC_P, CC_PZ, CC_ALW} cond_t;
endpackage

// ---- logic/exec_unit.sv ----
// arithmetic, flag, branch and low-power execution unit behind an axi4-lite slave
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module exec_unit (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic timer_irq,
  input wire logic external_irq_line_one,
  input wire logic external_irq_line_three,
  output logic osc_run,
  output logic timer_run,
  output logic sleeping,
  output logic irq_enable
);
  typedef enum {S_READY, S_FETCH, S_CMP} state_t;

  // packed decimal add; result {carry, byte}
  function automatic logic [8:0] bcd_add(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [4:0] lo;
    logic [4:0] hi;
    logic cl;
    logic ch;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    cl = lo > 5'h09;
    if (cl) lo = lo + 5'h06;
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, cl};
    ch = hi > 5'h09;
    if (ch) hi = hi + 5'h06;
    return {ch, hi[3:0], lo[3:0]};
  endfunction

  // packed decimal d - s - 1 + c; result {no_borrow, byte}
  function automatic logic [8:0] bcd_sub(input logic [7:0] d, input logic [7:0] s, input logic c);
    logic [4:0] lo;
    logic [4:0] hi;
    logic bl;
    logic bh;
    lo = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, ~c};
    bl = lo[4];
    if (bl) lo = lo + 5'h0a;
    hi = {1'b0, d[7:4]} - {1'b0, s[7:4]} - {4'h0, bl};
    bh = hi[4];
    if (bh) hi = hi + 5'h0a;
    return {~bh, hi[3:0], lo[3:0]};
  endfunction

  // next-instruction address plus signed byte offset
  function automatic logic [15:0] rel(input logic [15:0] pc, input logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction

  // flags from a byte result, carry supplied by caller
  function automatic logic [2:0] cnz(input logic c, input logic [7:0] r);
    return {c, r[7], r == 8'h00};
  endfunction

  // condition decode over {c,n,z,i}
  function automatic logic cond_ok(input logic [2:0] cc, input logic [3:0] st);
    case (exec_pkg::cond_t'(cc))
      exec_pkg::CC_C: return st[exec_pkg::ST_C];
      exec_pkg::CC_NC: return ~st[exec_pkg::ST_C];
      exec_pkg::CC_Z: return st[exec_pkg::ST_Z];
      exec_pkg::CC_NZ: return ~st[exec_pkg::ST_Z];
      exec_pkg::CC_N: return st[exec_pkg::ST_N];
      exec_pkg::CC_P: return ~st[exec_pkg::ST_N] & ~st[exec_pkg::ST_Z];
      exec_pkg::CC_PZ: return ~st[exec_pkg::ST_N];
      default: return 1'b1;
    endcase
  endfunction

  // byte-lane merge for strobed writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  state_t state_ff;
  state_t nxt_state;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [7:0] dst_ff, src_ff, nxt_dst;
  logic [15:0] pair_ff, pc_ff, xadr_ff, nxt_pair, nxt_pc, nxt_xadr;
  logic [3:0] st_ff, stk_st_ff, nxt_st, nxt_stk_st;
  logic [15:0] stk_pc_ff, nxt_stk_pc;
  logic [3:0] cfg_ff;
  logic [3:0] op_ff;
  logic [2:0] cond_ff;
  logic go_ff;
  logic [15:0] mem_addr_ff;
  logic mem_rd_ff;
  logic sleep_ff, osc_ff, tmr_ff;
  logic [1:0] pm_ff;

  // bus handshakes and decode
  wire aw_hs = awready_ff & awvalid & wvalid;
  wire ar_hs = arready_ff & arvalid;
  wire busy = go_ff | (state_ff != S_READY);
  wire wr_en = aw_hs & ~busy; // writes landing while busy are dropped
  wire [31:0] w_dst = merge({24'h0, dst_ff}, wdata, wstrb);
  wire [31:0] w_src = merge({24'h0, src_ff}, wdata, wstrb);
  wire [31:0] w_pair = merge({16'h0, pair_ff}, wdata, wstrb);
  wire [31:0] w_pc = merge({16'h0, pc_ff}, wdata, wstrb);
  wire [31:0] w_xadr = merge({16'h0, xadr_ff}, wdata, wstrb);
  wire [31:0] w_stat = merge({24'h0, st_ff, 4'h0}, wdata, wstrb);
  wire [31:0] w_cfg = merge({28'h0, cfg_ff}, wdata, wstrb);
  wire wr_map = (awaddr <= exec_pkg::ADDR_CFG) && (awaddr[1:0] == 2'h0);
  wire cmd_wr = wr_en & (awaddr == exec_pkg::ADDR_CMD) & ~sleep_ff;
  wire [3:0] cmd_op = wdata[exec_pkg::CMD_OP_LSB +: 4];
  wire [2:0] cmd_cc = wdata[exec_pkg::CMD_COND_LSB +: 3];

  // operand address generation for the extended compare
  wire [1:0] amode = cfg_ff[exec_pkg::CFG_AMODE_LSB +: 2];
  wire [15:0] ea = (amode == exec_pkg::AM_INDIRECT) ? pair_ff :
                   (amode == exec_pkg::AM_INDEXED) ? (xadr_ff + {8'h00, src_ff}) : xadr_ff;

  // interrupt sources; timer source is dead while timers are stopped
  wire ext_any = external_irq_line_one | external_irq_line_three;
  wire irq_src = ext_any | (timer_irq & tmr_ff);
  wire take_irq = st_ff[exec_pkg::ST_I] & irq_src & ~busy;
  wire wake = (pm_ff == exec_pkg::PM_NMOS) ? take_irq :
              (pm_ff == exec_pkg::PM_WAKE) ? (ext_any | timer_irq) : ext_any;

  // compare result against the fetched byte, used in S_CMP
  wire [7:0] cmp_res = dst_ff - mem_rdata;
  wire cmp_lt = $signed(dst_ff) < $signed(mem_rdata);
  wire [8:0] dac_r = bcd_add(dst_ff, src_ff, st_ff[exec_pkg::ST_C]);
  wire [8:0] dsb_r = bcd_sub(dst_ff, src_ff, st_ff[exec_pkg::ST_C]);
  wire [7:0] dec_r = dst_ff - 8'h01;
  wire [7:0] inc_r = dst_ff + 8'h01;
  wire [15:0] subtract_one_pair_r = pair_ff - 16'h0001;
  wire [7:0] inv_r = ~dst_ff;

  // next-state for the datapath: software writes, then execution and interrupt entry
  always_comb begin
    nxt_state = state_ff;
    nxt_dst = dst_ff;
    nxt_pair = pair_ff;
    nxt_pc = pc_ff;
    nxt_xadr = xadr_ff;
    nxt_st = st_ff;
    nxt_stk_st = stk_st_ff;
    nxt_stk_pc = stk_pc_ff;
    if (wr_en) begin
      case (awaddr)
        exec_pkg::ADDR_DST: nxt_dst = w_dst[7:0];
        exec_pkg::ADDR_PAIR: nxt_pair = w_pair[15:0];
        exec_pkg::ADDR_PC: nxt_pc = w_pc[15:0];
        exec_pkg::ADDR_XADR: nxt_xadr = w_xadr[15:0];
        exec_pkg::ADDR_STAT: nxt_st = w_stat[7:4];
        default: ;
      endcase
    end
    if (go_ff) begin
      case (exec_pkg::op_t'(op_ff))
        exec_pkg::OP_COMPARE_ACC_EXTENDED: nxt_state = S_FETCH;
        exec_pkg::OP_DAC: begin
          nxt_dst = dac_r[7:0];
          nxt_st[3:1] = cnz(dac_r[8], dac_r[7:0]);
        end
        exec_pkg::OP_DSB: begin
          nxt_dst = dsb_r[7:0];
          nxt_st[3:1] = cnz(dsb_r[8], dsb_r[7:0]);
        end
        exec_pkg::OP_DEC: begin
          nxt_dst = dec_r;
          nxt_st[3:1] = cnz(dst_ff != 8'h00, dec_r);
        end
        exec_pkg::OP_SUBTRACT_ONE_PAIR: begin
          nxt_pair = subtract_one_pair_r;
          nxt_st[3:1] = cnz(pair_ff != 16'h0000, subtract_one_pair_r[15:8]);
        end
        exec_pkg::OP_INC: begin
          nxt_dst = inc_r;
          nxt_st[3:1] = cnz(dst_ff == 8'hff, inc_r);
        end
        exec_pkg::OP_INV: begin
          nxt_dst = inv_r;
          nxt_st[2:1] = {inv_r[7], inv_r == 8'h00};
        end
        exec_pkg::OP_COUNT_DOWN_LOOP_BRANCH: begin
          nxt_dst = dec_r; // flags untouched
          if (dec_r != 8'h00) nxt_pc = rel(pc_ff, src_ff);
        end
        exec_pkg::OP_JMP: nxt_pc = rel(pc_ff, src_ff);
        exec_pkg::OP_JCOND: begin
          if (cond_ok(cond_ff, st_ff)) nxt_pc = rel(pc_ff, src_ff);
        end
        exec_pkg::OP_GLOBAL_IRQ_OFF: nxt_st = 4'h0;
        exec_pkg::OP_GLOBAL_IRQ_ON: nxt_st = 4'hf;
        exec_pkg::OP_RETURN_FROM_INTERRUPT: begin
          nxt_st = stk_st_ff;
          nxt_pc = stk_pc_ff;
        end
        exec_pkg::OP_POPST: nxt_st = stk_st_ff;
        default: ;
      endcase
    end
    case (state_ff)
      S_FETCH: nxt_state = S_CMP;
      S_CMP: begin
        nxt_state = S_READY;
        nxt_st[3:1] = {dst_ff >= mem_rdata, cmp_lt, cmp_res == 8'h00};
      end
      default: ;
    endcase
    // entry saves the old status first, the cleared enable only lands in the live copy
    if (take_irq) begin
      nxt_stk_st = st_ff;
      nxt_stk_pc = sleep_ff ? (pc_ff + 16'h0001) : pc_ff;
      nxt_st[exec_pkg::ST_I] = 1'b0;
    end else if (sleep_ff && wake) begin
      nxt_pc = pc_ff + 16'h0001;
    end
  end

  // read mux; unmapped offsets answer with slverr
  always_comb begin
    rd_hit = 1'b1;
    case (araddr)
      exec_pkg::ADDR_CMD: rd_word = {25'h0, cond_ff, op_ff};
      exec_pkg::ADDR_DST: rd_word = {24'h0, dst_ff};
      exec_pkg::ADDR_SRC: rd_word = {24'h0, src_ff};
      exec_pkg::ADDR_PAIR: rd_word = {16'h0, pair_ff};
      exec_pkg::ADDR_STAT: rd_word = {24'h0, st_ff, 4'h0};
      exec_pkg::ADDR_PC: rd_word = {16'h0, pc_ff};
      exec_pkg::ADDR_XADR: rd_word = {16'h0, xadr_ff};
      exec_pkg::ADDR_CFG: rd_word = {28'h0, cfg_ff};
      exec_pkg::ADDR_STATE: rd_word = {26'h0, pm_ff, tmr_ff, osc_ff, sleep_ff, busy};
      exec_pkg::ADDR_STACK: rd_word = {12'h0, stk_st_ff, stk_pc_ff};
      default: begin
        rd_word = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // axi4-lite channel registers; address and data are taken together
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= exec_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= exec_pkg::RESP_OKAY;
      rdata_ff <= 32'h0;
    end else begin
      awready_ff <= awvalid & wvalid & ~awready_ff & ~bvalid_ff;
      wready_ff <= awvalid & wvalid & ~awready_ff & ~bvalid_ff;
      if (aw_hs) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
      arready_ff <= arvalid & ~arready_ff & ~rvalid_ff;
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // datapath and sequencing registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= S_READY;
      dst_ff <= exec_pkg::BYTE_RST;
      src_ff <= exec_pkg::BYTE_RST;
      pair_ff <= exec_pkg::PC_RST;
      pc_ff <= exec_pkg::PC_RST;
      xadr_ff <= exec_pkg::PC_RST;
      st_ff <= exec_pkg::STAT_RST;
      stk_st_ff <= exec_pkg::STAT_RST;
      stk_pc_ff <= exec_pkg::PC_RST;
      cfg_ff <= 4'h0;
      op_ff <= 4'h0;
      cond_ff <= 3'h0;
      go_ff <= 1'b0;
      mem_addr_ff <= exec_pkg::PC_RST;
      mem_rd_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dst_ff <= nxt_dst;
      pair_ff <= nxt_pair;
      pc_ff <= nxt_pc;
      xadr_ff <= nxt_xadr;
      st_ff <= nxt_st;
      stk_st_ff <= nxt_stk_st;
      stk_pc_ff <= nxt_stk_pc;
      go_ff <= cmd_wr;
      if (wr_en && awaddr == exec_pkg::ADDR_SRC) src_ff <= w_src[7:0];
      if (wr_en && awaddr == exec_pkg::ADDR_CFG) cfg_ff <= w_cfg[3:0];
      if (cmd_wr) begin
        op_ff <= cmd_op;
        cond_ff <= cmd_cc;
      end
      // operand read strobe lasts the whole fetch cycle
      mem_rd_ff <= go_ff && op_ff == exec_pkg::OP_COMPARE_ACC_EXTENDED;
      if (go_ff && op_ff == exec_pkg::OP_COMPARE_ACC_EXTENDED) mem_addr_ff <= ea;
    end
  end

  // low-power state; reset itself is the other release path
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_ff <= 1'b0;
      osc_ff <= 1'b1;
      tmr_ff <= 1'b1;
      pm_ff <= 2'h0;
    end else if (go_ff && op_ff == exec_pkg::OP_IDLE) begin
      sleep_ff <= 1'b1; // pc is held while asleep
      pm_ff <= cfg_ff[exec_pkg::CFG_PMODE_LSB +: 2];
      osc_ff <= cfg_ff[exec_pkg::CFG_PMODE_LSB +: 2] != exec_pkg::PM_HALT_OFF;
      tmr_ff <= cfg_ff[exec_pkg::CFG_PMODE_LSB +: 2] < exec_pkg::PM_HALT_OFF;
    end else if (sleep_ff && wake) begin
      sleep_ff <= 1'b0;
      osc_ff <= 1'b1;
      tmr_ff <= 1'b1;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_rd = mem_rd_ff;
  assign sleeping = sleep_ff;
  assign osc_run = osc_ff;
  assign timer_run = tmr_ff;
  assign irq_enable = st_ff[exec_pkg::ST_I];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_compare_acc_extended_flags: assert property (state_ff == S_CMP |=> st_ff[3:1] ==
    {$past(dst_ff) >= $past(mem_rdata), $signed($past(dst_ff)) < $signed($past(mem_rdata)),
     $past(dst_ff) == $past(mem_rdata)}) else $error("compare flags wrong");
  a_compare_acc_extended_fetch: assert property (go_ff && op_ff == exec_pkg::OP_COMPARE_ACC_EXTENDED |=>
    mem_rd_ff && mem_addr_ff == $past(ea) ##1 !mem_rd_ff ##1 !busy) else $error("compare fetch sequence wrong");
  a_dec_carry: assert property (go_ff && op_ff == exec_pkg::OP_DEC |=>
    dst_ff == $past(dst_ff) - 8'h01 && st_ff[exec_pkg::ST_C] == ($past(dst_ff) != 8'h00)) else $error("dec wrong");
  a_inc_carry: assert property (go_ff && op_ff == exec_pkg::OP_INC |=>
    st_ff[exec_pkg::ST_C] == (dst_ff == 8'h00)) else $error("inc carry wrong");
  a_global_irq_off_flags: assert property (go_ff && op_ff == exec_pkg::OP_GLOBAL_IRQ_OFF |=> st_ff == 4'h0)
    else $error("irq off flags");
  a_global_irq_on_flags: assert property (go_ff && op_ff == exec_pkg::OP_GLOBAL_IRQ_ON |=> st_ff == 4'hf)
    else $error("irq on flags");
  a_count_down_loop_branch_keep: assert property (go_ff && op_ff == exec_pkg::OP_COUNT_DOWN_LOOP_BRANCH |=> $stable(st_ff))
    else $error("loop flags moved");
  a_irq_push: assert property (take_irq |=> stk_st_ff == $past(st_ff) && !st_ff[exec_pkg::ST_I])
    else $error("irq entry order wrong");
  a_jmp_target: assert property (go_ff && op_ff == exec_pkg::OP_JMP |=>
    pc_ff == $past(pc_ff) + {{8{$past(src_ff[7])}}, $past(src_ff)}) else $error("branch target wrong");
  a_halt_timers: assert property (sleep_ff && pm_ff >= exec_pkg::PM_HALT_OFF |-> !tmr_ff)
    else $error("timers run in halt");
  a_return_from_interrupt_restore: assert property (go_ff && op_ff == exec_pkg::OP_RETURN_FROM_INTERRUPT |=>
    st_ff == $past(stk_st_ff) && pc_ff == $past(stk_pc_ff)) else $error("return restore wrong");

  c_compare_acc_extended_done: cover property (state_ff == S_CMP ##1 st_ff[exec_pkg::ST_Z]);
  c_wake_halt: cover property (sleep_ff && pm_ff == exec_pkg::PM_HALT_OFF ##1 !sleep_ff);
  c_irq_idle: cover property (sleep_ff && take_irq);
endmodule

// ---- verif/exec_unit_tb.sv ----
// self-checking bench for the arithmetic, branch and low-power execution unit
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module exec_unit_tb;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, mem_rdata = 8'h00, mem_val = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic timer_irq = 1'h0, external_irq_line_one = 1'h0, external_irq_line_three = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, mem_rd, osc_run, timer_run, sleeping, irq_enable;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mem_addr;
  int error_cnt = 0;
  int n_checks = 0;

  exec_unit DUT (.ref_clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .mem_addr, .mem_rd, .mem_rdata, .timer_irq, .external_irq_line_one, .external_irq_line_three,
    .osc_run, .timer_run, .sleeping, .irq_enable);

  always #20 ref_clk = ~ref_clk;

  // operand memory: valid only in the cycle after a fetch, inverted otherwise so stale data never matches
  always @(posedge ref_clk) mem_rdata <= mem_rd ? mem_val : ~mem_val;

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // bus write: hold address and data until the ready seen in a cycle is taken at that cycle's closing edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(negedge ref_clk); while (!(awready && wready));
    @(posedge ref_clk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(negedge ref_clk); while (!bvalid);
    `CHK(bresp, er)
    @(posedge ref_clk);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge ref_clk); while (!arready);
    @(posedge ref_clk);
    arvalid <= 1'h0;
    do @(negedge ref_clk); while (!rvalid);
    d = rdata;
    `CHK(rresp, er)
    @(posedge ref_clk);
    rready <= 1'h0;
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] v;
    rd(a, v, er);
    `CHK(v, e)
  endtask

  // issue a command and poll busy so the next write is never dropped
  task automatic op(input logic [3:0] o, input logic [2:0] c = 3'h0);
    logic [31:0] v;
    wr(exec_pkg::ADDR_CMD, {25'h0, c, o});
    do rd(exec_pkg::ADDR_STATE, v); while (v[0]);
  endtask

  task automatic alu(input logic [3:0] o, input logic [3:0] fi, input logic [7:0] d, input logic [7:0] s,
                     input logic [7:0] ed, input logic [3:0] fe);
    wr(exec_pkg::ADDR_STAT, {24'h0, fi, 4'h0});
    wr(exec_pkg::ADDR_DST, {24'h0, d});
    wr(exec_pkg::ADDR_SRC, {24'h0, s});
    op(o);
    chk(exec_pkg::ADDR_DST, {24'h0, ed});
    chk(exec_pkg::ADDR_STAT, {24'h0, fe, 4'h0});
  endtask

  // compare: flags {c,n,z,i} and fetch address, accumulator left untouched
  task automatic compare_acc_extended(input logic [1:0] am, input logic [7:0] a, input logic [7:0] m,
                      input logic [15:0] ea, input logic [3:0] fe);
    wr(exec_pkg::ADDR_CFG, {30'h0, am});
    wr(exec_pkg::ADDR_DST, {24'h0, a});
    mem_val = m;
    op(exec_pkg::OP_COMPARE_ACC_EXTENDED);
    chk(exec_pkg::ADDR_STAT, {24'h0, fe, 4'h0});
    chk(exec_pkg::ADDR_DST, {24'h0, a});
    `CHK(mem_addr, ea)
  endtask

  task automatic pair(input logic [15:0] p, input logic [15:0] pe, input logic [3:0] fe);
    wr(exec_pkg::ADDR_STAT, 32'h0);
    wr(exec_pkg::ADDR_PAIR, {16'h0, p});
    op(exec_pkg::OP_SUBTRACT_ONE_PAIR);
    chk(exec_pkg::ADDR_PAIR, {16'h0, pe});
    chk(exec_pkg::ADDR_STAT, {24'h0, fe, 4'h0});
  endtask

  // expected branch decision, f = {c, n, z}
  function automatic logic take(input logic [2:0] c, input logic [2:0] f);
    case (c)
      3'h0: return f[2];
      3'h1: return !f[2];
      3'h2: return f[0];
      3'h3: return !f[0];
      3'h4: return f[1];
      3'h5: return !f[1] && !f[0];
      3'h6: return !f[1];
      default: return 1'h1;
    endcase
  endfunction

  // raise one wake source for two cycles: 0 timer, 1 external line one, 2 external line three
  task automatic pulse(input int k);
    @(posedge ref_clk);
    if (k == 0) timer_irq <= 1'h1;
    else if (k == 1) external_irq_line_one <= 1'h1;
    else external_irq_line_three <= 1'h1;
    repeat (2) @(posedge ref_clk);
    timer_irq <= 1'h0;
    external_irq_line_one <= 1'h0;
    external_irq_line_three <= 1'h0;
    repeat (4) @(negedge ref_clk);
  endtask

  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(negedge ref_clk);
    `CHK({irq_enable, sleeping, osc_run, timer_run}, 4'h3)
    chk(exec_pkg::ADDR_STAT, 32'h0);
    chk(8'h28, 32'h0, exec_pkg::RESP_SLVERR);
    wr(8'h28, 32'h5a, exec_pkg::RESP_SLVERR);
    wr(exec_pkg::ADDR_XADR, 32'h1234);
    wr(exec_pkg::ADDR_PAIR, 32'habcd);
    wr(exec_pkg::ADDR_SRC, 32'h10);
    compare_acc_extended(2'h0, 8'h80, 8'h7f, 16'h1234, 4'hc);
    compare_acc_extended(2'h1, 8'h7f, 8'h7f, 16'habcd, 4'ha);
    compare_acc_extended(2'h2, 8'h00, 8'h01, 16'h1244, 4'h4);
    compare_acc_extended(2'h0, 8'h01, 8'hff, 16'h1234, 4'h0);
    alu(exec_pkg::OP_DAC, 4'h8, 8'h58, 8'h46, 8'h05, 4'h8);
    alu(exec_pkg::OP_DAC, 4'h0, 8'h50, 8'h50, 8'h00, 4'ha);
    alu(exec_pkg::OP_DAC, 4'h0, 8'h12, 8'h34, 8'h46, 4'h0);
    alu(exec_pkg::OP_DSB, 4'h8, 8'h30, 8'h12, 8'h18, 4'h8);
    alu(exec_pkg::OP_DSB, 4'h0, 8'h30, 8'h12, 8'h17, 4'h8);
    alu(exec_pkg::OP_DSB, 4'h8, 8'h10, 8'h20, 8'h90, 4'h4);
    alu(exec_pkg::OP_DEC, 4'h0, 8'h00, 8'h00, 8'hff, 4'h4);
    alu(exec_pkg::OP_DEC, 4'h0, 8'h01, 8'h00, 8'h00, 4'ha);
    alu(exec_pkg::OP_INC, 4'h0, 8'hff, 8'h00, 8'h00, 4'ha);
    alu(exec_pkg::OP_INC, 4'h8, 8'h7f, 8'h00, 8'h80, 4'h4);
    alu(exec_pkg::OP_INV, 4'h8, 8'hff, 8'h00, 8'h00, 4'ha);
    alu(exec_pkg::OP_INV, 4'h0, 8'h2a, 8'h00, 8'hd5, 4'h4);
    pair(16'h0000, 16'hffff, 4'h4);
    pair(16'h0100, 16'h00ff, 4'ha);
    op(exec_pkg::OP_GLOBAL_IRQ_ON);
    chk(exec_pkg::ADDR_STAT, 32'hf0);
    `CHK(irq_enable, 1'h1)
    op(exec_pkg::OP_GLOBAL_IRQ_OFF);
    chk(exec_pkg::ADDR_STAT, 32'h00);
    `CHK(irq_enable, 1'h0)
    // loop branch: taken while nonzero, flags kept
    wr(exec_pkg::ADDR_PC, 32'h100);
    alu(exec_pkg::OP_COUNT_DOWN_LOOP_BRANCH, 4'h2, 8'h02, 8'h10, 8'h01, 4'h2);
    chk(exec_pkg::ADDR_PC, 32'h110);
    alu(exec_pkg::OP_COUNT_DOWN_LOOP_BRANCH, 4'h2, 8'h01, 8'h10, 8'h00, 4'h2);
    chk(exec_pkg::ADDR_PC, 32'h110);
    wr(exec_pkg::ADDR_PC, 32'h200);
    alu(exec_pkg::OP_JMP, 4'h4, 8'h00, 8'h80, 8'h00, 4'h4);
    chk(exec_pkg::ADDR_PC, 32'h180);
    alu(exec_pkg::OP_JMP, 4'h4, 8'h00, 8'h7f, 8'h00, 4'h4);
    chk(exec_pkg::ADDR_PC, 32'h1ff);
    // every condition against every flag pattern; offset 4 so a taken branch lands at 0x104
    wr(exec_pkg::ADDR_SRC, 32'h4);
    for (int f = 0; f < 8; f++) begin
      for (int c = 0; c < 8; c++) begin
        wr(exec_pkg::ADDR_STAT, {24'h0, f[2:0], 5'h0});
        wr(exec_pkg::ADDR_PC, 32'h100);
        op(exec_pkg::OP_JCOND, c[2:0]);
        chk(exec_pkg::ADDR_PC, take(c[2:0], f[2:0]) ? 32'h104 : 32'h100);
      end
    end
    // interrupt entry saves status before clearing the enable
    op(exec_pkg::OP_GLOBAL_IRQ_ON);
    wr(exec_pkg::ADDR_PC, 32'h300);
    pulse(1);
    chk(exec_pkg::ADDR_STACK, 32'hf0300);
    chk(exec_pkg::ADDR_STAT, 32'he0);
    wr(exec_pkg::ADDR_STAT, 32'h0);
    op(exec_pkg::OP_POPST);
    `CHK(irq_enable, 1'h1)
    op(exec_pkg::OP_GLOBAL_IRQ_OFF);
    op(exec_pkg::OP_RETURN_FROM_INTERRUPT);
    chk(exec_pkg::ADDR_STAT, 32'hf0);
    // idle in the plain mode: pc held, resumes after the idle
    wr(exec_pkg::ADDR_CFG, 32'h0);
    wr(exec_pkg::ADDR_PC, 32'h400);
    op(exec_pkg::OP_IDLE);
    repeat (4) @(negedge ref_clk);
    `CHK(sleeping, 1'h1)
    chk(exec_pkg::ADDR_PC, 32'h400);
    pulse(2);
    chk(exec_pkg::ADDR_STACK, 32'hf0401);
    op(exec_pkg::OP_RETURN_FROM_INTERRUPT);
    chk(exec_pkg::ADDR_PC, 32'h401);
    op(exec_pkg::OP_GLOBAL_IRQ_OFF);
    // low-power flavours with the enable off: only the wake mode answers the timer
    for (int m = 1; m < 4; m++) begin
      wr(exec_pkg::ADDR_CFG, 32'(m * 4));
      wr(exec_pkg::ADDR_PC, 32'h500);
      op(exec_pkg::OP_IDLE);
      `CHK({sleeping, osc_run, timer_run}, {1'h1, m != 2, m == 1})
      pulse(0);
      `CHK(sleeping, m != 1)
      pulse(1);
      `CHK({sleeping, osc_run, timer_run}, 3'h3)
      chk(exec_pkg::ADDR_PC, 32'h501);
    end
    finish_test();
  end
endmodule
